// ### qsbp_pkg.sv
package qsbp_pkg;
  // word address width of the modelled array (one location per burst word)
  localparam int AW = 4;
  // data word width and byte lanes (18-bit variant: two 9-bit lanes)
  localparam int DW = 18;
  localparam int LN = 2;
  localparam int LW = 9;
  // depth of the write trace buffer
  localparam int TRACE_DEPTH = 16;
  // values after reset
  localparam logic [DW-1:0] DATA_RST = 18'h00000;
  localparam logic [AW-1:0] ADDR_RST = 4'h0;
  localparam logic [LN-1:0] MASK_RST = 2'h3;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_HALF = 2'b10
  } qsbp_wstate_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] d1;
    logic [DW-1:0] d0;
    logic [LN-1:0] m1_n;
    logic [LN-1:0] m0_n;
  } qsbp_burst_t;
endpackage : qsbp_pkg

// ### qsbp_port.sv
// Behaviour
// - a write starts on a rising link edge with the write select low, word one taken there, word two and the address on the falling edge.
// - a read starts on a rising link edge with the read select low and drives word one 1.5 cycles later and word two a half cycle after that.
// - after power-up both ports are idle and the read outputs are released.
// - the first word uses the captured address and the second word that address plus one.
// - write data is taken on both link edges and read data is launched on both link edges.
// - the byte selects are sampled separately with each word of a write burst.
// - in the 18-bit form select 0 gates bits 8:0 and select 1 gates bits 17:9, masked lanes keep their contents.
// - in the 18-bit form both selects high leave that word untouched.
// - in the 36-bit form all selects low write the whole word.
// - in the 36-bit form each select gates one 9-bit lane and all high write nothing.
// - after the second read word the outputs release at the next output edge.
// - the port selects are sampled only on rising edges and each port runs on its own, pending bursts finishing.
// - a read of a location written by a write one edge earlier returns the new data.
`timescale 1ns/1ps
`default_nettype none
module qsbp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // depth must be a power of two, pointers wrap freely
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop)
      rp_nxt = rp_r + 1'b1;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    mem_r <= mem_nxt;
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : qsbp_fifo

module qsbp_port (
  // core clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // link input clock, falling edge stands for the inverted clock rise
  input wire logic LINK_CLK,
  // command and address
  input wire logic READ_PORT_SELECT_N,
  input wire logic WRITE_PORT_SELECT_N,
  input wire logic [qsbp_pkg::AW-1:0] ADDR,
  // write data
  input wire logic [qsbp_pkg::DW-1:0] WRITE_BITS_IN,
  input wire logic [qsbp_pkg::LN-1:0] BYTE_WRITE_SELECT_N,
  // read data
  output logic [qsbp_pkg::DW-1:0] READ_BITS_OUT,
  output logic READ_BITS_OE,
  // write trace stream on the core clock
  output logic TRACE_VALID,
  input wire logic TRACE_READY,
  output qsbp_pkg::qsbp_burst_t TRACE_DATA,
  output logic TRACE_IN_READY
);
  localparam int AW = qsbp_pkg::AW;
  localparam int DW = qsbp_pkg::DW;
  localparam int LN = qsbp_pkg::LN;
  localparam int LW = qsbp_pkg::LW;

  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w, input logic [LN-1:0] sel_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int i = 0; i < LN; i++)
      if (!sel_n[i])
        r[i*LW +: LW] = new_w[i*LW +: LW];
    return r;
  endfunction : lane_merge

  // link reset, NRST brought over two flops
  logic [1:0] lrs_r;
  logic lrst_n;
  always_ff @(posedge LINK_CLK)
    lrs_r <= {lrs_r[0], NRST};
  assign lrst_n = lrs_r[1];

  // rising-edge link state
  qsbp_pkg::qsbp_wstate_t wst_r, wst_nxt;
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] mem_nxt [2**AW];
  logic [DW-1:0] w0_r, w0_nxt, rdat0_r, rdat0_nxt, rdat1_r, rdat1_nxt, q_pos_r, q_pos_nxt;
  logic [LN-1:0] m0_r, m0_nxt;
  logic [AW-1:0] raddr_r, raddr_nxt, ra1, wa1;
  logic rd_p1_r, rd_p1_nxt, rd_p2_r, rd_p2_nxt, oe_pos_r, oe_pos_nxt;
  logic hs_req_r, hs_req_nxt, commit, busy;
  logic [1:0] ack_s_r;
  logic ack_r;
  qsbp_pkg::qsbp_burst_t hs_data_r, hs_data_nxt;
  // falling-edge link state
  logic [AW-1:0] waddr_r, waddr_nxt;
  logic [DW-1:0] w1_r, w1_nxt, q_neg_r, q_neg_nxt;
  logic [LN-1:0] m1_r, m1_nxt;
  logic oe_neg_r, oe_neg_nxt;

  assign commit = (wst_r == qsbp_pkg::WS_HALF);
  assign ra1 = raddr_r + 1'b1;
  assign wa1 = waddr_r + 1'b1;
  assign busy = hs_req_r ^ ack_s_r[1];

  always_comb
  begin
    wst_nxt = WRITE_PORT_SELECT_N ? qsbp_pkg::WS_IDLE : qsbp_pkg::WS_HALF;
    w0_nxt = WRITE_PORT_SELECT_N ? w0_r : WRITE_BITS_IN;
    m0_nxt = WRITE_PORT_SELECT_N ? m0_r : BYTE_WRITE_SELECT_N;
    rd_p1_nxt = !READ_PORT_SELECT_N;
    raddr_nxt = READ_PORT_SELECT_N ? raddr_r : ADDR;
    rd_p2_nxt = rd_p1_r;
    mem_nxt = mem_r;
    if (commit)
    begin
      mem_nxt[waddr_r] = lane_merge(mem_r[waddr_r], w0_r, m0_r);
      mem_nxt[wa1] = lane_merge(mem_r[wa1], w1_r, m1_r);
    end
    // fetch sees this edge's commit, which forwards a just-written burst
    rdat0_nxt = rd_p1_r ? mem_nxt[raddr_r] : rdat0_r;
    rdat1_nxt = rd_p1_r ? mem_nxt[ra1] : rdat1_r;
    q_pos_nxt = rd_p2_r ? rdat1_r : q_pos_r;
    oe_pos_nxt = rd_p2_r;
    hs_req_nxt = hs_req_r;
    hs_data_nxt = hs_data_r;
    // trace is best effort: a burst arriving while one is in flight is not traced
    if (commit && !busy)
    begin
      hs_req_nxt = ~hs_req_r;
      hs_data_nxt = '{addr: waddr_r, d1: w1_r, d0: w0_r, m1_n: m1_r, m0_n: m0_r};
    end
  end

  // no clock edges while the link stops, so everything holds
  always_ff @(posedge LINK_CLK)
  begin
    mem_r <= mem_nxt;
    w0_r <= w0_nxt;
    rdat0_r <= rdat0_nxt;
    rdat1_r <= rdat1_nxt;
    q_pos_r <= q_pos_nxt;
    hs_data_r <= hs_data_nxt;
    ack_s_r <= {ack_s_r[0], ack_r};
    if (!lrst_n)
    begin
      wst_r <= qsbp_pkg::WS_IDLE;
      m0_r <= qsbp_pkg::MASK_RST;
      raddr_r <= qsbp_pkg::ADDR_RST;
      rd_p1_r <= 1'b0;
      rd_p2_r <= 1'b0;
      oe_pos_r <= 1'b0;
      hs_req_r <= 1'b0;
    end
    else
    begin
      wst_r <= wst_nxt;
      m0_r <= m0_nxt;
      raddr_r <= raddr_nxt;
      rd_p1_r <= rd_p1_nxt;
      rd_p2_r <= rd_p2_nxt;
      oe_pos_r <= oe_pos_nxt;
      hs_req_r <= hs_req_nxt;
    end
  end

  always_comb
  begin
    waddr_nxt = commit ? ADDR : waddr_r;
    w1_nxt = commit ? WRITE_BITS_IN : w1_r;
    m1_nxt = commit ? BYTE_WRITE_SELECT_N : m1_r;
    q_neg_nxt = rd_p2_r ? rdat0_r : q_neg_r;
    oe_neg_nxt = rd_p2_r;
  end

  always_ff @(negedge LINK_CLK)
  begin
    w1_r <= w1_nxt;
    q_neg_r <= q_neg_nxt;
    if (!lrst_n)
    begin
      waddr_r <= qsbp_pkg::ADDR_RST;
      m1_r <= qsbp_pkg::MASK_RST;
      oe_neg_r <= 1'b0;
    end
    else
    begin
      waddr_r <= waddr_nxt;
      m1_r <= m1_nxt;
      oe_neg_r <= oe_neg_nxt;
    end
  end

  // double-rate launch: each half of the link cycle shows its own register
  assign READ_BITS_OUT = LINK_CLK ? q_pos_r : q_neg_r;
  assign READ_BITS_OE = LINK_CLK ? oe_pos_r : oe_neg_r;

  // core side: reset sync, handshake receive, trace buffer
  logic [1:0] nrs_r, req_s_r;
  logic rst_n, ack_nxt, in_valid, in_ready;
  always_ff @(posedge CLOCK)
  begin
    nrs_r <= {nrs_r[0], NRST};
    req_s_r <= {req_s_r[0], hs_req_r};
  end
  assign rst_n = nrs_r[1];
  // hs_data_r is stable while a request is open
  assign in_valid = req_s_r[1] ^ ack_r;
  always_comb
    ack_nxt = ack_r ^ (in_valid && in_ready);
  always_ff @(posedge CLOCK)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= ack_nxt;
  end
  assign TRACE_IN_READY = in_ready;

  qsbp_fifo #(
    .W($bits(qsbp_pkg::qsbp_burst_t)),
    .DEPTH(qsbp_pkg::TRACE_DEPTH)
  ) u_trace (
    .clk(CLOCK),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(hs_data_r),
    .out_valid(TRACE_VALID),
    .out_ready(TRACE_READY),
    .out_data(TRACE_DATA)
  );

  sequence s_rd_start;
    !READ_PORT_SELECT_N;
  endsequence
  sequence s_rd_burst;
    ##2 rd_p2_r ##1 oe_pos_r;
  endsequence
  sequence s_wr_start;
    !WRITE_PORT_SELECT_N;
  endsequence

  a_rd_two_word: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    s_rd_start |-> s_rd_burst) else $error("read burst not driven");
  a_rd_idle_quiet: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    READ_PORT_SELECT_N |-> ##3 !oe_pos_r) else $error("read output driven without read");
  a_rd_release: assert property (@(negedge LINK_CLK) disable iff (!lrst_n)
    (oe_pos_r && !rd_p2_r) |=> !oe_neg_r) else $error("read output not released");
  a_power_quiet: assert property (@(posedge LINK_CLK)
    !lrst_n |=> !oe_pos_r && !rd_p1_r) else $error("outputs active after reset");
  a_rd_addr_hold: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    s_rd_start |=> raddr_r == $past(ADDR)) else $error("read address not captured");
  a_wr_commit: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    s_wr_start |=> commit && w0_r == $past(WRITE_BITS_IN)
      && m0_r == $past(BYTE_WRITE_SELECT_N)) else $error("write burst not committed");
  a_full_word: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    (commit && m0_r == '0) |=> mem_r[$past(waddr_r)] == $past(w0_r))
    else $error("full word not written");
  a_lane_keep: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    (commit && m0_r[0]) |=> mem_r[$past(waddr_r)][LW-1:0] == $past(mem_r[waddr_r][LW-1:0]))
    else $error("masked lane changed");
  a_word_two_mask: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    (commit && m1_r == '1) |=> mem_r[$past(wa1)] == $past(mem_r[wa1]))
    else $error("masked second word changed");
  a_fwd_read: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    (rd_p1_r && commit && waddr_r == raddr_r && m0_r == '0) |=> rdat0_r == $past(w0_r))
    else $error("write data not forwarded");
  a_trace_hold: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (TRACE_VALID && !TRACE_READY) |=> TRACE_VALID && $stable(TRACE_DATA))
    else $error("trace word dropped while stalled");
endmodule : qsbp_port
`default_nettype wire

// ### qsbp_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module qsbp_ctl (
  // link clock
  output logic lk,
  // commands and write data
  output logic rps_n,
  output logic wps_n,
  output logic [qsbp_pkg::AW-1:0] addr,
  output logic [qsbp_pkg::DW-1:0] wd,
  output logic [qsbp_pkg::LN-1:0] bws_n,
  // read data
  input wire logic [qsbp_pkg::DW-1:0] rd,
  input wire logic oe
);
  logic run;
  initial
  begin
    run = 1'b1;
    lk = 1'b1;
    rps_n = 1'b1;
    wps_n = 1'b1;
    addr = 4'h0;
    wd = 18'h2aaaa;
    bws_n = 2'h3;
  end
  // parked high when stopped, for the quickest restart
  // output clocks held high: only the single-clock form exists here
  always #6 lk = run ? ~lk : 1'b1;
  // read words sampled mid-phase, clear of both launching edges
  task automatic grab(output logic [17:0] q0, q1, output logic [2:0] o);
    @(negedge lk);
    @(posedge lk);
    @(negedge lk);
    #3;
    q0 = rd;
    o[0] = oe;
    @(posedge lk);
    #3;
    q1 = rd;
    o[1] = oe;
    @(negedge lk);
    #3;
    o[2] = oe;
  endtask : grab
  task automatic wr(input logic [3:0] a, input logic [17:0] w0, w1, input logic [1:0] m0, m1);
    @(posedge lk);
    wps_n <= 1'b0;
    wd <= w0;
    bws_n <= m0;
    @(posedge lk);
    wps_n <= 1'b1;
    addr <= a;
    wd <= w1;
    bws_n <= m1;
  endtask : wr
  task automatic rdb(input logic [3:0] a, output logic [17:0] q0, q1, output logic [2:0] o);
    @(posedge lk);
    rps_n <= 1'b0;
    addr <= a;
    // stale write inputs scrambled so a missed select shows
    wd <= ~wd;
    bws_n <= ~bws_n;
    @(posedge lk);
    rps_n <= 1'b1;
    addr <= ~a;
    grab(q0, q1, o);
  endtask : rdb
  // read and full-word write started on one edge at one location
  task automatic rwb(input logic [3:0] a, input logic [17:0] w0, w1,
      output logic [17:0] q0, q1, output logic [2:0] o);
    @(posedge lk);
    rps_n <= 1'b0;
    wps_n <= 1'b0;
    addr <= a;
    wd <= w0;
    bws_n <= 2'h0;
    @(posedge lk);
    rps_n <= 1'b1;
    wps_n <= 1'b1;
    wd <= w1;
    grab(q0, q1, o);
  endtask : rwb
  task automatic nop(input int n);
    repeat (n)
    begin
      @(posedge lk);
      wd <= ~wd;
      bws_n <= 2'h0;
    end
  endtask : nop
endmodule : qsbp_ctl
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic nrst;
  logic trace_ready;
  logic lk;
  logic rps_n;
  logic wps_n;
  logic [qsbp_pkg::AW-1:0] addr;
  logic [qsbp_pkg::DW-1:0] wd;
  logic [qsbp_pkg::LN-1:0] bws_n;
  logic [qsbp_pkg::DW-1:0] rd;
  logic oe;
  logic trace_valid;
  logic trace_in_ready;
  qsbp_pkg::qsbp_burst_t trace_data;
  int err_count = 0;
  int checks_done = 0;
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    trace_ready = 1'b0;
  end
  always #5 clk = ~clk;
  qsbp_port qsbp_port_inst (.CLOCK(clk), .NRST(nrst), .LINK_CLK(lk),
    .READ_PORT_SELECT_N(rps_n), .WRITE_PORT_SELECT_N(wps_n), .ADDR(addr),
    .WRITE_BITS_IN(wd), .BYTE_WRITE_SELECT_N(bws_n), .READ_BITS_OUT(rd),
    .READ_BITS_OE(oe), .TRACE_VALID(trace_valid), .TRACE_READY(trace_ready),
    .TRACE_DATA(trace_data), .TRACE_IN_READY(trace_in_ready));
  qsbp_ctl qsbp_ctl_inst (.lk(lk), .rps_n(rps_n), .wps_n(wps_n), .addr(addr),
    .wd(wd), .bws_n(bws_n), .rd(rd), .oe(oe));
  task automatic chk(input logic [43:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // sampled on the falling core edge, clear of the launching edge
  task automatic pop(input logic [3:0] a, input logic [17:0] w0, w1, input logic [1:0] m0, m1);
    int n;
    n = 0;
    @(negedge clk);
    while (trace_valid !== 1'b1 && n < 80)
    begin
      @(negedge clk);
      n++;
    end
    chk(44'(trace_data), {a, w1, w0, m1, m0});
    @(posedge clk);
    trace_ready <= 1'b1;
    @(posedge clk);
    trace_ready <= 1'b0;
  endtask : pop
  task automatic rchk(input logic [3:0] a, input logic [17:0] e0, e1);
    logic [17:0] q0;
    logic [17:0] q1;
    logic [2:0] o;
    qsbp_ctl_inst.rdb(a, q0, q1, o);
    chk(44'(q0), 44'(e0));
    chk(44'(q1), 44'(e1));
    chk(44'(o), 44'h3);
  endtask : rchk
  task automatic t_basic;
    qsbp_ctl_inst.wr(4'h3, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
    // read back of the burst just written
    rchk(4'h3, 18'h12345, 18'h2abcd);
    pop(4'h3, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
  endtask : t_basic
  task automatic t_fwd;
    logic [17:0] q0;
    logic [17:0] q1;
    logic [2:0] o;
    qsbp_ctl_inst.rwb(4'h9, 18'h15a5a, 18'h0c3c3, q0, q1, o);
    chk(44'(q0), 44'h15a5a);
    chk(44'(q1), 44'h0c3c3);
    chk(44'(o), 44'h3);
    pop(4'h9, 18'h15a5a, 18'h0c3c3, 2'h0, 2'h0);
  endtask : t_fwd
  task automatic t_mask;
    logic [17:0] x0;
    logic [17:0] x1;
    logic [17:0] y0;
    logic [17:0] y1;
    x0 = 18'h0f0f0;
    x1 = 18'h3c3c3;
    y0 = 18'h3ffff;
    y1 = 18'h2aaaa;
    qsbp_ctl_inst.wr(4'h5, x0, x1, 2'h0, 2'h0);
    pop(4'h5, x0, x1, 2'h0, 2'h0);
    qsbp_ctl_inst.wr(4'h5, y0, y1, 2'h1, 2'h2);
    pop(4'h5, y0, y1, 2'h1, 2'h2);
    qsbp_ctl_inst.wr(4'h5, 18'h0, 18'h0, 2'h3, 2'h3);
    pop(4'h5, 18'h0, 18'h0, 2'h3, 2'h3);
    rchk(4'h5, {y0[17:9], x0[8:0]}, {x1[17:9], y1[8:0]});
  endtask : t_mask
  task automatic t_wrap;
    qsbp_ctl_inst.wr(4'hf, 18'h1b00f, 18'h24ff0, 2'h0, 2'h0);
    pop(4'hf, 18'h1b00f, 18'h24ff0, 2'h0, 2'h0);
    rchk(4'hf, 18'h1b00f, 18'h24ff0);
  endtask : t_wrap
  task automatic t_idle;
    qsbp_ctl_inst.nop(4);
    #3;
    chk(44'(oe), 44'h0);
    rchk(4'h3, 18'h12345, 18'h2abcd);
    qsbp_ctl_inst.run = 1'b0;
    #60;
    chk(44'(oe), 44'h0);
    qsbp_ctl_inst.run = 1'b1;
    rchk(4'h3, 18'h12345, 18'h2abcd);
  endtask : t_idle
  // spaced writes: the trace drops bursts that outrun the crossing
  task automatic t_fill;
    for (int i = 0; i < 17; i++)
    begin
      qsbp_ctl_inst.wr(4'(i), 18'(i), 18'(i + 1), 2'h0, 2'h0);
      qsbp_ctl_inst.nop(6);
    end
    chk(44'(trace_in_ready), 44'h0);
    for (int i = 0; i < 16; i++)
      pop(4'(i), 18'(i), 18'(i + 1), 2'h0, 2'h0);
  endtask : t_fill
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge lk);
    #3;
    chk(44'({oe, trace_valid, trace_in_ready}), 44'h1);
    t_basic();
    t_fwd();
    t_mask();
    t_wrap();
    t_idle();
    t_fill();
    give_verdict();
  end
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
